/* logic/fifo_readout_pkg.sv */
/*
 * Constants and register map of the sample buffer read-out port.
 * Assumes a register access port that presents one byte address and a read strobe per byte.
 */
// Notes on behaviour
// [RL1] Lost sample sets overflow flag bit 7
// [RL2] Over-reading sets underflow flag bit 6
// [RL3] Flags sticky; cleared by power-on or flush
// [RL4] Fill count low bits in status 1:0
// [RL5] Data register serves single and block reads
// [RL6] Each data read pops one byte
// [RL7] Empty read returns zero, sets underflow
// [RL8] Host checks flags before and after read-out
// [RL9] Host reads upper count before lower status
// [RL10] Buffer holds 512 bytes, count 0..512
// [RL11] Fill interrupt when count exceeds threshold; the code compares the count with twice the threshold
// [RL12] Upper count read latches lower status
package fifo_readout_pkg;
  localparam logic [7:0] ADDR_FILL_THRESHOLD = 8'hfc;
  localparam logic [7:0] ADDR_FILL_UPPER     = 8'hfd;
  localparam logic [7:0] ADDR_FLAGS_LOWER    = 8'hfe;
  localparam logic [7:0] ADDR_POP_WINDOW     = 8'hff;
  localparam int         OVERFLOW_BIT        = 7;
  localparam int         UNDERFLOW_BIT       = 6;
  localparam int         BUF_DEPTH           = 512;
  localparam int         COUNT_W             = 10;
  localparam int         STAGE_DEPTH         = 32;
  localparam logic [7:0] THRESHOLD_RESET     = 8'h7f;
  localparam logic [7:0] STATUS_RESET        = 8'h00;
  localparam logic [7:0] EMPTY_READ_VALUE    = 8'h00;
  // Sample cycles between lost-event toggles, above three system cycles
  localparam int         LOST_GAP            = 24;
endpackage : fifo_readout_pkg

/* logic/sample_fifo_readout_port.sv */
/*
 * Read-out side of the sample buffer: status, level, pop window and fill interrupt.
 * Assumes samples arrive as bytes on the sample clock with a ready handshake, and that
 * register reads arrive as single-cycle strobes on sys_clk from the serial bus slave.
 */
`timescale 1ns/1ps
`default_nettype none
module sample_fifo_readout_port
  import fifo_readout_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Sample side
  input  wire logic       sample_clk,
  input  wire logic       sample_rst,
  input  wire logic [7:0] sample_data,
  input  wire logic       sample_valid,
  output logic            sample_ready,
  input  wire logic       sample_drop,
  // Register side
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_rvalid,
  // Control
  input  wire logic       power_on_bit,
  input  wire logic       buffer_flush_command,
  output logic            fill_interrupt
);
  localparam int AW = $clog2(DEPTH);

  // ************************************************
  // Sample-clock staging buffer
  // ************************************************
  logic       lost_pulse;
  logic       clear_req;
  logic       pon_q;
  logic [7:0] st_data;
  logic       st_valid;
  logic       st_ready;
  logic [7:0] cd_data_q;
  logic       cd_full_q;
  logic       cd_tog_q;
  logic       cd_ack_s1_q;
  logic       cd_ack_s2_q;
  logic       cd_ack_s3_q;
  logic       flush_seen;

  // Samples offered while the staging buffer is full are lost
  assign lost_pulse = sample_drop || (sample_valid && !sample_ready);

  toggle_sync flush_xing (
    .src_clk   (sys_clk),
    .src_rst   (srst),
    .src_pulse (clear_req),
    .dst_clk   (sample_clk),
    .dst_rst   (sample_rst),
    .dst_pulse (flush_seen)
  );

  stage_fifo #(
    .WIDTH (8),
    .DEPTH (STAGE_DEPTH)
  ) stage (
    .sys_clk   (sample_clk),
    .srst      (sample_rst),
    .flush     (flush_seen),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (st_data),
    .out_valid (st_valid),
    .out_ready (st_ready)
  );

  // ************************************************
  // Word handshake into the system clock
  // ************************************************
  logic ack_tog_q;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic word_arrive;

  assign st_ready = !cd_full_q;

  always_ff @(posedge sample_clk) begin
    if (sample_rst) begin
      cd_data_q   <= 8'h00;
      cd_full_q   <= 1'b0;
      cd_tog_q    <= 1'b0;
      cd_ack_s1_q <= 1'b0;
      cd_ack_s2_q <= 1'b0;
      cd_ack_s3_q <= 1'b0;
    end else begin
      cd_ack_s1_q <= ack_tog_q;
      cd_ack_s2_q <= cd_ack_s1_q;
      cd_ack_s3_q <= cd_ack_s2_q;
      if (st_valid && !cd_full_q) begin
        cd_data_q <= st_data;
        cd_full_q <= 1'b1;
        cd_tog_q  <= ~cd_tog_q;
      end else if (cd_ack_s2_q != cd_ack_s3_q) begin
        cd_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      req_s1_q  <= 1'b0;
      req_s2_q  <= 1'b0;
      req_s3_q  <= 1'b0;
      ack_tog_q <= 1'b0;
    end else begin
      req_s1_q <= cd_tog_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      if (req_s2_q != req_s3_q) begin
        ack_tog_q <= ~ack_tog_q;
      end
    end
  end

  assign word_arrive = (req_s2_q != req_s3_q);

  // ************************************************
  // Lost-sample events, spaced for the crossing
  // ************************************************
  logic       lost_hold_q;
  logic [4:0] lost_gap_q;
  logic       lost_fire;
  logic       lost_sys;

  // Bursts of losses merge so no toggle cancels another
  assign lost_fire = (lost_pulse || lost_hold_q) && (lost_gap_q == 5'h0);

  always_ff @(posedge sample_clk) begin
    if (sample_rst) begin
      lost_hold_q <= 1'b0;
      lost_gap_q  <= 5'h0;
    end else if (lost_fire) begin
      lost_hold_q <= 1'b0;
      lost_gap_q  <= 5'(LOST_GAP);
    end else begin
      if (lost_pulse) begin
        lost_hold_q <= 1'b1;
      end
      if (lost_gap_q != 5'h0) begin
        lost_gap_q <= lost_gap_q - 5'h1;
      end
    end
  end

  toggle_sync lost_xing (
    .src_clk   (sample_clk),
    .src_rst   (sample_rst),
    .src_pulse (lost_fire),
    .dst_clk   (sys_clk),
    .dst_rst   (srst),
    .dst_pulse (lost_sys)
  );

  // ************************************************
  // Main buffer and level
  // ************************************************
  logic [7:0]       buf_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [COUNT_W-1:0] level_q;
  logic             full;
  logic             push;
  logic             pop_req;
  logic             pop;
  logic             over_read;
  logic             pon_s1_q;
  logic             pon_s2_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pon_s1_q <= 1'b0;
      pon_s2_q <= 1'b0;
      pon_q    <= 1'b0;
    end else begin
      pon_s1_q <= power_on_bit;
      pon_s2_q <= pon_s1_q;
      pon_q    <= pon_s2_q;
    end
  end

  // [RL3] Power-on rise or flush
  assign clear_req = buffer_flush_command || (pon_s2_q && !pon_q);

  // [RL10] Count 0 to full
  assign full      = (level_q == COUNT_W'(DEPTH));
  assign push      = word_arrive && !full && !clear_req;
  // [RL5] Any read of the pop window
  assign pop_req   = reg_rd && (reg_addr == ADDR_POP_WINDOW);
  assign pop       = pop_req && (level_q != '0) && !clear_req;
  // [RL7] Empty read
  assign over_read = pop_req && (level_q == '0);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      buf_q[wp_q] <= cd_data_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || clear_req) begin
      wp_q    <= '0;
      rp_q    <= '0;
      level_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + AW'(1);
      end
      // [RL6] Advance and decrement
      if (pop) begin
        rp_q <= rp_q + AW'(1);
      end
      level_q <= level_q + COUNT_W'(push) - COUNT_W'(pop);
    end
  end

  // ************************************************
  // Sticky flags
  // ************************************************
  logic overflow_q;
  logic underflow_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      overflow_q  <= 1'b0;
      underflow_q <= 1'b0;
    end else begin
      // [RL1] Lost sample sets overflow
      if (lost_sys || (word_arrive && full)) begin
        overflow_q <= 1'b1;
      end else if (clear_req) begin
        overflow_q <= 1'b0;
      end
      // [RL2] Over-read sets underflow
      if (over_read) begin
        underflow_q <= 1'b1;
      end else if (clear_req) begin
        underflow_q <= 1'b0;
      end
    end
  end

  // ************************************************
  // Threshold and interrupt
  // ************************************************
  logic [7:0] threshold_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      threshold_q <= THRESHOLD_RESET;
    end else if (reg_wr && (reg_addr == ADDR_FILL_THRESHOLD)) begin
      threshold_q <= reg_wdata;
    end
  end

  // [RL11] Level above twice the threshold
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fill_interrupt <= 1'b0;
    end else begin
      fill_interrupt <= (level_q > {1'b0, threshold_q, 1'b0});
    end
  end

  // ************************************************
  // Register read path
  // ************************************************
  logic [7:0] status_live;
  logic [7:0] status_snap_q;
  logic       snap_valid_q;

  always_comb begin
    status_live = STATUS_RESET;
    status_live[OVERFLOW_BIT]  = overflow_q;
    status_live[UNDERFLOW_BIT] = underflow_q;
    // [RL4] Low level bits
    status_live[1:0] = level_q[1:0];
  end

  // [RL12] Upper read latches status
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_snap_q <= STATUS_RESET;
      snap_valid_q  <= 1'b0;
    end else if (reg_rd && (reg_addr == ADDR_FILL_UPPER)) begin
      status_snap_q <= status_live;
      snap_valid_q  <= 1'b1;
    end else if (reg_rd && (reg_addr == ADDR_FLAGS_LOWER)) begin
      snap_valid_q  <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_FILL_THRESHOLD: reg_rdata <= threshold_q;
          ADDR_FILL_UPPER:     reg_rdata <= level_q[COUNT_W-1:2];
          ADDR_FLAGS_LOWER:    reg_rdata <= snap_valid_q ? status_snap_q : status_live;
          // [RL7] Zero when empty
          ADDR_POP_WINDOW:     reg_rdata <= (level_q != '0) ? buf_q[rp_q] : EMPTY_READ_VALUE;
          default:             reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule : sample_fifo_readout_port
`default_nettype wire

/* logic/stage_fifo.sv */
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module stage_fifo
  import fifo_readout_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = STAGE_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : stage_fifo
`default_nettype wire

/* logic/toggle_sync.sv */
/*
 * Carries one-cycle events from a source clock into the destination clock by a toggle.
 * Assumes source events are spaced at least three destination cycles apart.
 */
`timescale 1ns/1ps
`default_nettype none
module toggle_sync (
  input  wire logic src_clk,
  input  wire logic src_rst,
  input  wire logic src_pulse,
  input  wire logic dst_clk,
  input  wire logic dst_rst,
  output logic      dst_pulse
);
  logic tog_q;
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      tog_q <= 1'b0;
    end else if (src_pulse) begin
      tog_q <= ~tog_q;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= tog_q;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign dst_pulse = s2_q ^ s3_q;
endmodule : toggle_sync
`default_nettype wire

/* testbench/fifo_readout_asserts.sv */
/* Checker for the read-out port register side.
   Sees only top-level ports; bound below. */
`timescale 1ns/1ps
`default_nettype none
module fifo_readout_asserts
  import fifo_readout_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       buffer_flush_command,
  input wire logic       fill_interrupt
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_flush_pop;
    buffer_flush_command ##2 (reg_rd && reg_addr == ADDR_POP_WINDOW);
  endsequence
  sequence s_pop_stat;
    s_flush_pop ##2 (reg_rd && reg_addr == ADDR_FLAGS_LOWER);
  endsequence
  a_rvalid_follows: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  a_no_stray: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without read");
  a_unmapped_zero: assert property (reg_rd && reg_addr < ADDR_FILL_THRESHOLD |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_empty_pop_zero: assert property (s_flush_pop |=> reg_rdata == EMPTY_READ_VALUE)
    else $error("empty pop not zero");
  a_pop_sets_under: assert property (s_pop_stat |=> reg_rdata[UNDERFLOW_BIT])
    else $error("underflow flag not set");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_flush_irq_low: assert property (buffer_flush_command |-> ##[1:3] !fill_interrupt)
    else $error("interrupt stays after flush");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !reg_rvalid && reg_rdata == STATUS_RESET)
    else $error("outputs not quiet in reset");
endmodule : fifo_readout_asserts
bind sample_fifo_readout_port fifo_readout_asserts #(.DEPTH(DEPTH)) u_fifo_readout_asserts (
  .sys_clk(sys_clk), .srst(srst), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .buffer_flush_command(buffer_flush_command), .fill_interrupt(fill_interrupt));
`default_nettype wire

/* testbench/host_reg_model.sv */
/* Host model: byte register reads and writes.
   Drives at falling edge of sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module host_reg_model
  import fifo_readout_pkg::*;
(
  input  wire logic       sys_clk,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask : wr
  task automatic level(output logic [7:0] up, output logic [7:0] st);
    rd(ADDR_FILL_UPPER, up);
    rd(ADDR_FLAGS_LOWER, st);
  endtask : level
endmodule : host_reg_model
`default_nettype wire

/* testbench/sample_fifo_readout_port_tb.sv */
/* Testbench of the read-out port.
   Host model on register side; bench drives samples. */
`timescale 1ns/1ps
`default_nettype none
module sample_fifo_readout_port_tb;
  import fifo_readout_pkg::*;
  localparam int DEPTH = 64;
  logic sys_clk = 0, srst = 1, sample_clk = 0, sample_rst = 1;
  logic [7:0] sample_data = 0, reg_addr, reg_wdata, reg_rdata, up, st, d;
  logic sample_valid = 0, sample_ready, sample_drop = 0, reg_rd, reg_wr, reg_rvalid;
  logic power_on_bit = 0, buffer_flush_command = 0, fill_interrupt, refused;
  int err_total = 0, checks_done = 0;
  always #20 sys_clk = ~sys_clk;
  initial #1.7 forever #3 sample_clk = ~sample_clk;
  sample_fifo_readout_port #(.DEPTH(DEPTH)) u_sample_fifo_readout_port (
    .sys_clk(sys_clk), .srst(srst), .sample_clk(sample_clk), .sample_rst(sample_rst),
    .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_drop(sample_drop), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .power_on_bit(power_on_bit), .buffer_flush_command(buffer_flush_command),
    .fill_interrupt(fill_interrupt));
  host_reg_model u_host_reg_model (.sys_clk(sys_clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cycles
  task automatic flush();
    @(negedge sys_clk) buffer_flush_command = 1'b1;
    @(negedge sys_clk) buffer_flush_command = 1'b0;
  endtask : flush
  task automatic push(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(negedge sample_clk);
      if (sample_valid && !sample_ready) refused = 1'b1;
      sample_valid = 1'b1;
      sample_data = base + 8'(i);
    end
    @(negedge sample_clk) sample_valid = 1'b0;
  endtask : push
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // ****************
  // Scenarios
  // ****************
  task automatic t_empty();
    flush();
    u_host_reg_model.rd(ADDR_POP_WINDOW, d);
    chk(d, EMPTY_READ_VALUE);
    u_host_reg_model.rd(ADDR_FLAGS_LOWER, d);
    chk(d, 8'h40);
    u_host_reg_model.rd(8'h10, d);
    chk(d, 8'h00);
    flush();
    u_host_reg_model.rd(ADDR_FLAGS_LOWER, d);
    chk(d, 8'h00);
  endtask : t_empty
  task automatic t_fill();
    u_host_reg_model.wr(ADDR_FILL_THRESHOLD, 8'h05);
    u_host_reg_model.rd(ADDR_FILL_THRESHOLD, d);
    chk(d, 8'h05);
    flush();
    push(22, 8'h10);
    // Each byte takes a full two-clock handshake
    cycles(120);
    u_host_reg_model.level(up, st);
    chk(up, 8'h05);
    chk(st, 8'h02);
    chk({7'h0, fill_interrupt}, 8'h01);
    u_host_reg_model.rd(ADDR_FILL_UPPER, up);
    chk(up, 8'h05);
    u_host_reg_model.rd(ADDR_POP_WINDOW, d);
    chk(d, 8'h10);
    u_host_reg_model.rd(ADDR_FLAGS_LOWER, st);
    chk(st, 8'h02);
    u_host_reg_model.rd(ADDR_FLAGS_LOWER, st);
    chk(st, 8'h01);
    for (int i = 1; i < 22; i++) begin
      u_host_reg_model.rd(ADDR_POP_WINDOW, d);
      chk(d, 8'h10 + 8'(i));
    end
    cycles(3);
    u_host_reg_model.level(up, st);
    chk(up, 8'h00);
    chk(st, 8'h00);
    chk({7'h0, fill_interrupt}, 8'h00);
  endtask : t_fill
  task automatic t_over();
    flush();
    refused = 1'b0;
    push(1200, 8'h00);
    // Staging must drain before the flush
    cycles(200);
    chk({7'h0, refused}, 8'h01);
    u_host_reg_model.level(up, st);
    chk(up, 8'(DEPTH / 4));
    chk(st, 8'h80);
    flush();
    cycles(3);
    u_host_reg_model.rd(ADDR_FLAGS_LOWER, d);
    chk(d, 8'h00);
  endtask : t_over
  task automatic t_pon();
    @(negedge sample_clk) sample_drop = 1'b1;
    @(negedge sample_clk) sample_drop = 1'b0;
    cycles(10);
    u_host_reg_model.rd(ADDR_FLAGS_LOWER, d);
    chk(d, 8'h80);
    power_on_bit = 1'b1;
    cycles(5);
    power_on_bit = 1'b0;
    u_host_reg_model.rd(ADDR_FLAGS_LOWER, d);
    chk(d, 8'h00);
  endtask : t_pon
  initial begin
    cycles(3);
    srst = 1'b0;
    sample_rst = 1'b0;
    t_empty();
    t_fill();
    t_over();
    t_pon();
    close_out();
  end
  initial begin
    #200us;
    err_total++;
    close_out();
  end
endmodule : sample_fifo_readout_port_tb
`default_nettype wire
